// >>> core/sle_top.sv
// extra-lane enable registers on apb with per-link lane control
`timescale 1ns/100ps
`default_nettype none
`include "sle_params.svh"
module sle_top (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // device settings, same clock
   input wire logic link_encoder_enable,
   input wire logic [7:0] link_mode_select_lanes_a,
   input wire logic [7:0] link_mode_select_lanes_b,
   input wire logic [3:0] test_pattern_select,
   input wire logic [1:0] channel_power_down,
   // lane controls
   output sle_pkg::sle_link_out_t link_a_lanes,
   output sle_pkg::sle_link_out_t link_b_lanes,
   // link subsystem power
   output logic serdes_pll_en,
   output logic multiframe_clk_en
);
   typedef struct packed {
      sle_pkg::sle_extra_t extra_a;
      sle_pkg::sle_extra_t extra_b;
      logic wwe;
      logic subsys_on;
      sle_pkg::sle_apb_rsp_t rsp;
   } sle_state_t;

   sle_state_t q;
   sle_state_t d;
   logic setup;
   logic access;
   logic wr_ok;
   logic link_a_on;
   logic link_b_on;
   logic wwe_set;
   logic wwe_clr;

   function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
      hit = (a[11:2] == idx);
   endfunction : hit

   function automatic logic mapped(input logic [11:0] a);
      mapped = hit(a, `SLE_IDX_EXTRA_A) || hit(a, `SLE_IDX_EXTRA_B)
         || hit(a, `SLE_IDX_STAT_CLK) || hit(a, `SLE_IDX_STAT_SER);
   endfunction : mapped

   always_comb begin
      d = q;
      setup = psel && !penable;
      access = psel && penable && q.rsp.pready;
      wr_ok = access && pwrite && mapped(paddr) && pstrb[0];
      // a powered-down channel keeps its link dark
      link_a_on = !channel_power_down[0]; // RULE8
      link_b_on = !channel_power_down[1]; // RULE8
      d.subsys_on = !(&channel_power_down); // RULE10

      if (wr_ok && hit(paddr, `SLE_IDX_EXTRA_A)) begin
         d.extra_a = pwdata[7:0]; // RULE1 RULE3
      end
      if (wr_ok && hit(paddr, `SLE_IDX_EXTRA_B)) begin
         d.extra_b = pwdata[7:0]; // RULE2 RULE4
      end

      // a write while the encoder runs is flagged, not blocked
      wwe_set = wr_ok && link_encoder_enable
         && (hit(paddr, `SLE_IDX_EXTRA_A) || hit(paddr, `SLE_IDX_EXTRA_B)); // RULE5
      wwe_clr = access && pwrite && pstrb[3] && hit(paddr, `SLE_IDX_STAT_CLK)
         && pwdata[`SLE_WWE_BIT];
      if (wwe_set) begin
         d.wwe = 1'b1;
      end else if (wwe_clr) begin
         d.wwe = 1'b0;
      end

      d.rsp.pready = setup;
      d.rsp.pslverr = setup && !mapped(paddr);
      d.rsp.prdata = '0;
      if (setup && !pwrite) begin
         if (hit(paddr, `SLE_IDX_EXTRA_A)) begin
            d.rsp.prdata = {24'h000000, q.extra_a};
         end else if (hit(paddr, `SLE_IDX_EXTRA_B)) begin
            d.rsp.prdata = {24'h000000, q.extra_b};
         end else if (hit(paddr, `SLE_IDX_STAT_CLK)) begin
            d.rsp.prdata = {q.wwe, q.subsys_on, 14'h0000,
               link_b_lanes.clk_en, link_a_lanes.clk_en};
         end else if (hit(paddr, `SLE_IDX_STAT_SER)) begin
            d.rsp.prdata = {16'h0000, link_b_lanes.ser_en, link_a_lanes.ser_en};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   sle_lane_ctl u_link_a (
      .pclk(pclk),
      .presetn(presetn),
      .extra(q.extra_a),
      .mode_lanes(link_mode_select_lanes_a),
      .test_sel(test_pattern_select),
      .link_on(link_a_on),
      .lanes(link_a_lanes)
   );

   sle_lane_ctl u_link_b (
      .pclk(pclk),
      .presetn(presetn),
      .extra(q.extra_b),
      .mode_lanes(link_mode_select_lanes_b),
      .test_sel(test_pattern_select),
      .link_on(link_b_on),
      .lanes(link_b_lanes)
   );

   assign prdata = q.rsp.prdata;
   assign pready = q.rsp.pready;
   assign pslverr = q.rsp.pslverr;
   assign serdes_pll_en = q.subsys_on;
   assign multiframe_clk_en = q.subsys_on;

   // forced lane clocks follow the register one cycle later
   property p_a_forced_clk;
      @(posedge pclk) disable iff (!presetn)
      !channel_power_down[0] |=>
         ((link_a_lanes.clk_en[7:1] & $past(q.extra_a.lanes))
            == $past(q.extra_a.lanes));
   endproperty
   a_a_forced_clk: assert property (p_a_forced_clk) // RULE1
      else $error("link a forced lane clock missing");

   property p_b_forced_clk;
      @(posedge pclk) disable iff (!presetn)
      !channel_power_down[1] |=>
         ((link_b_lanes.clk_en[7:1] & $past(q.extra_b.lanes))
            == $past(q.extra_b.lanes));
   endproperty
   a_b_forced_clk: assert property (p_b_forced_clk) // RULE2
      else $error("link b forced lane clock missing");

   property p_a_clk_only;
      @(posedge pclk) disable iff (!presetn)
      (!q.extra_a.ser && link_mode_select_lanes_a == 8'h00)
         |=> (link_a_lanes.ser_en == 8'h00);
   endproperty
   a_a_clk_only: assert property (p_a_clk_only) // RULE3
      else $error("link a serializer on without serializer enable");

   property p_b_ser_on;
      @(posedge pclk) disable iff (!presetn)
      (q.extra_b == 8'hFF && link_mode_select_lanes_b[0] && !channel_power_down[1])
         |=> (link_b_lanes.ser_en == 8'hFF);
   endproperty
   a_b_ser_on: assert property (p_b_ser_on) // RULE4
      else $error("link b forced serializers not powered");

   property p_mode_pattern;
      @(posedge pclk) disable iff (!presetn)
      link_mode_select_lanes_a[2]
         |=> (link_a_lanes.pattern[2] == $past(test_pattern_select));
   endproperty
   a_mode_pattern: assert property (p_mode_pattern) // RULE6
      else $error("mode lane pattern differs from test select");

   property p_ramp;
      @(posedge pclk) disable iff (!presetn)
      (q.extra_b.lanes[5] && !link_mode_select_lanes_b[5] && !channel_power_down[1]
         && (test_pattern_select == 4'h0 || test_pattern_select == 4'h5))
         |=> (link_b_lanes.ramp[5] && link_b_lanes.pattern[5] == 4'h4);
   endproperty
   a_ramp: assert property (p_ramp) // RULE7
      else $error("forced lane did not switch to octet ramp");

   property p_pd_off;
      @(posedge pclk) disable iff (!presetn)
      channel_power_down[0] ##1 channel_power_down[0]
         |=> (link_a_lanes.clk_en == 8'h00 && link_a_lanes.ser_en == 8'h00);
   endproperty
   a_pd_off: assert property (p_pd_off) // RULE8
      else $error("powered-down link a has active lanes");

   property p_ser_chain;
      @(posedge pclk) disable iff (!presetn)
      ((link_a_lanes.ser_en[7:1] & ~link_a_lanes.ser_en[6:0]) == 7'h00)
         && ((link_b_lanes.ser_en[7:1] & ~link_b_lanes.ser_en[6:0]) == 7'h00);
   endproperty
   a_ser_chain: assert property (p_ser_chain) // RULE9
      else $error("serializer clocked with a lower lane off");

   property p_subsys_off;
      @(posedge pclk) disable iff (!presetn)
      (channel_power_down == 2'b11)
         |=> (!serdes_pll_en && !multiframe_clk_en);
   endproperty
   a_subsys_off: assert property (p_subsys_off) // RULE10
      else $error("link subsystem powered with both channels down");

   property p_or_gate;
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> (link_b_lanes.clk_en == ($past(link_mode_select_lanes_b
         | {q.extra_b.lanes, 1'b0}) & {8{!$past(channel_power_down[1])}}));
   endproperty
   a_or_gate: assert property (p_or_gate) // RULE11
      else $error("link b lane enable is not mode or extra");

   property p_apb_write;
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && pwrite && pstrb[0]
         && paddr[11:2] == 10'h20A)
         |=> (q.extra_a == $past(pwdata[7:0]));
   endproperty
   a_apb_write: assert property (p_apb_write)
      else $error("extra lane a write not stored");

   property p_apb_ready;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready ##1 !pready;
   endproperty
   a_apb_ready: assert property (p_apb_ready)
      else $error("apb ready not one cycle after setup");

   property p_wwe;
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && pwrite && pstrb[0] && link_encoder_enable
         && paddr[11:2] == 10'h20B) |=> q.wwe;
   endproperty
   a_wwe: assert property (p_wwe) // RULE5
      else $error("write under running encoder not flagged");

   property p_wwe_clr;
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && pwrite && pstrb[3] && pwdata[`SLE_WWE_BIT]
         && paddr[11:2] == `SLE_IDX_STAT_CLK) |=> !q.wwe;
   endproperty
   a_wwe_clr: assert property (p_wwe_clr)
      else $error("write-while-enabled flag not cleared");

   property p_strb_ignore;
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && pwrite && !pstrb[0])
         |=> ($stable(q.extra_a) && $stable(q.extra_b));
   endproperty
   a_strb_ignore: assert property (p_strb_ignore)
      else $error("write without byte lane 0 changed a register");

   property p_apb_err;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !mapped(paddr))
         |=> (pslverr && prdata == 32'h0000_0000);
   endproperty
   a_apb_err: assert property (p_apb_err)
      else $error("unmapped access not flagged as error");

   property p_rd_a;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr[11:2] == `SLE_IDX_EXTRA_A)
         |=> (prdata == {24'h000000, $past(q.extra_a)});
   endproperty
   a_rd_a: assert property (p_rd_a) // RULE1
      else $error("extra lane a read data wrong");

   property p_a_ramp_alt;
      @(posedge pclk) disable iff (!presetn)
      (q.extra_a.lanes[1] && !link_mode_select_lanes_a[1] && !channel_power_down[0]
         && test_pattern_select == `SLE_TP_ALT)
         |=> (link_a_lanes.ramp[1] && link_a_lanes.pattern[1] == `SLE_TP_RAMP);
   endproperty
   a_a_ramp_alt: assert property (p_a_ramp_alt) // RULE7
      else $error("link a forced lane did not send octet ramp");

   property p_no_ramp;
      @(posedge pclk) disable iff (!presetn)
      (test_pattern_select != `SLE_TP_OFF && test_pattern_select != `SLE_TP_ALT)
         |=> (link_a_lanes.ramp == 8'h00 && link_b_lanes.ramp == 8'h00);
   endproperty
   a_no_ramp: assert property (p_no_ramp) // RULE6
      else $error("octet ramp under a pattern that keeps its own format");

   property p_b_pd_off;
      @(posedge pclk) disable iff (!presetn)
      channel_power_down[1]
         |=> (link_b_lanes.clk_en == 8'h00 && link_b_lanes.ser_en == 8'h00);
   endproperty
   a_b_pd_off: assert property (p_b_pd_off) // RULE8
      else $error("powered-down link b has active lanes");

   property p_a_ser_lane0;
      @(posedge pclk) disable iff (!presetn)
      !link_mode_select_lanes_a[0] |=> (link_a_lanes.ser_en == 8'h00);
   endproperty
   a_a_ser_lane0: assert property (p_a_ser_lane0) // RULE9
      else $error("link a serializer clocked without lane 0");

   property p_subsys_on;
      @(posedge pclk) disable iff (!presetn)
      (channel_power_down != 2'b11)
         |=> (serdes_pll_en && multiframe_clk_en);
   endproperty
   a_subsys_on: assert property (p_subsys_on) // RULE10
      else $error("link subsystem off with a channel powered");
endmodule : sle_top
`default_nettype wire

// >>> core/sle_params.svh
// constants of the extra-lane enable block
// What this block does
// RULE1 - link A lane field bits 7:1 force link clocks of lanes 1-7 on
// RULE2 - link B lane field bits 7:1 force link clocks of lanes 1-7 on
// RULE3 - link A bit 0 high also powers forced serializers; low, clocks only
// RULE4 - link B bit 0 high also powers forced serializers; low, clocks only
// RULE5 - software changes extra-lane registers only while link encoder is off; code still takes such writes and sets the wwe flag
// RULE6 - forced lanes take rate and format from link mode and test pattern
// RULE7 - forced-only lane with test pattern 0 or 5 sends octet ramp (pattern 4)
// RULE8 - extra lanes never override channel power down; powered-down link stays off
// RULE9 - serializer n gets a clock only if lanes 0 to n-1 are enabled
// RULE10 - both channels down turns off serializer PLL and multiframe clock
// RULE11 - lane enable is mode need OR extra bit, gated by link power
`ifndef SLE_PARAMS_SVH
`define SLE_PARAMS_SVH
`define SLE_IDX_EXTRA_A 10'h20A
`define SLE_IDX_EXTRA_B 10'h20B
`define SLE_IDX_STAT_CLK 10'h2F0
`define SLE_IDX_STAT_SER 10'h2F1
`define SLE_EXTRA_RST 8'h00
`define SLE_SER_BIT 0
`define SLE_WWE_BIT 31
`define SLE_SUBSYS_BIT 30
`define SLE_TP_OFF 4'h0
`define SLE_TP_RAMP 4'h4
`define SLE_TP_ALT 4'h5
`endif

// >>> core/sle_pkg.sv
// types shared by the extra-lane enable block
package sle_pkg;
   typedef struct packed {
      logic [7:1] lanes;
      logic ser;
   } sle_extra_t;

   typedef struct packed {
      logic [7:0] clk_en;
      logic [7:0] ser_en;
      logic [7:0] ramp;
      logic [7:0][3:0] pattern;
   } sle_link_out_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } sle_apb_rsp_t;
endpackage : sle_pkg

// >>> core/sle_lane_ctl.sv
// per-link lane clock, serializer and pattern control
`timescale 1ns/100ps
`default_nettype none
`include "sle_params.svh"
module sle_lane_ctl (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // settings
   input wire sle_pkg::sle_extra_t extra,
   input wire logic [7:0] mode_lanes,
   input wire logic [3:0] test_sel,
   input wire logic link_on,
   // lane controls
   output sle_pkg::sle_link_out_t lanes
);
   sle_pkg::sle_link_out_t q;
   sle_pkg::sle_link_out_t d;
   logic ramp_sel;
   logic [7:0] forced;
   logic [7:0] ser_want;

   always_comb begin
      d = q;
      ramp_sel = (test_sel == `SLE_TP_OFF) || (test_sel == `SLE_TP_ALT);
      forced = {extra.lanes, 1'b0};
      for (int n = 0; n < 8; n++) begin
         d.clk_en[n] = link_on && (mode_lanes[n] || forced[n]); // RULE1 RULE2 RULE8 RULE11
         ser_want[n] = link_on && (mode_lanes[n] || (forced[n] && extra.ser)); // RULE3 RULE4
         d.ramp[n] = d.clk_en[n] && forced[n] && !mode_lanes[n] && ramp_sel; // RULE7
         d.pattern[n] = d.ramp[n] ? `SLE_TP_RAMP : test_sel; // RULE6
      end
      // a serializer clock is chained through every lower lane
      d.ser_en[0] = ser_want[0];
      for (int n = 1; n < 8; n++) begin
         d.ser_en[n] = d.ser_en[n-1] && ser_want[n]; // RULE9
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign lanes = q;
endmodule : sle_lane_ctl
`default_nettype wire

// >>> testbench/sle_rx_model.sv
// receiver model that counts lanes carrying data
`timescale 1ns/100ps
`default_nettype none
module sle_rx_model (
   // lanes from the device
   input wire sle_pkg::sle_link_out_t link_a_lanes,
   input wire sle_pkg::sle_link_out_t link_b_lanes,
   // lanes seen carrying data
   output logic [3:0] data_lanes_a,
   output logic [3:0] data_lanes_b
);
   // a lane carries data only with serializer and link clock both on
   always_comb begin
      data_lanes_a = 4'($countones(link_a_lanes.ser_en & link_a_lanes.clk_en));
      data_lanes_b = 4'($countones(link_b_lanes.ser_en & link_b_lanes.clk_en));
   end
endmodule : sle_rx_model
`default_nettype wire

// >>> testbench/serial_link_extra_lane_enable_tb_top.sv
// self-checking bench for the extra-lane enable block
`timescale 1ns/100ps
`default_nettype none
`include "sle_params.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module serial_link_extra_lane_enable_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, err, enc, pll_en, mf_en;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, tp, rx_a, rx_b;
   logic [7:0] mode_a, mode_b, ext_a, ext_b;
   logic [1:0] pd;
   sle_pkg::sle_link_out_t lanes_a, lanes_b, ea, eb;
   int fails = 0;
   int checked = 0;
   localparam logic [11:0] ADDR_A = {`SLE_IDX_EXTRA_A, 2'b00};
   localparam logic [11:0] ADDR_B = {`SLE_IDX_EXTRA_B, 2'b00};
   localparam logic [11:0] ADDR_ST = {`SLE_IDX_STAT_CLK, 2'b00};
   localparam logic [11:0] ADDR_SS = {`SLE_IDX_STAT_SER, 2'b00};

   always #2.5 pclk = ~pclk;

   sle_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link_encoder_enable(enc),
      .link_mode_select_lanes_a(mode_a), .link_mode_select_lanes_b(mode_b),
      .test_pattern_select(tp), .channel_power_down(pd), .link_a_lanes(lanes_a),
      .link_b_lanes(lanes_b), .serdes_pll_en(pll_en), .multiframe_clk_en(mf_en));

   sle_rx_model rx (.link_a_lanes(lanes_a), .link_b_lanes(lanes_b),
      .data_lanes_a(rx_a), .data_lanes_b(rx_b));

   function automatic sle_pkg::sle_link_out_t expect_lanes(input logic [7:0] m,
      input logic [7:0] x, input logic [3:0] t, input logic on);
      sle_pkg::sle_link_out_t r;
      logic chain;
      r = '0;
      chain = 1'b1;
      for (int n = 0; n < 8; n++) begin
         r.clk_en[n] = on & (m[n] | (x[n] & (n != 0)));
         chain = chain & on & (m[n] | (x[n] & x[0] & (n != 0)));
         r.ser_en[n] = chain;
         r.ramp[n] = r.clk_en[n] & x[n] & ~m[n] & (n != 0) & (t == 4'h0 | t == 4'h5);
         r.pattern[n] = r.ramp[n] ? 4'h4 : t;
      end
      return r;
   endfunction : expect_lanes

   // one idle edge first, so a back-to-back call never drives psel twice at once
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // reads right after the edge see the values the slave showed at it
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : wrap_up

   initial begin
      #20000;
      fails++;
      wrap_up();
   end

   initial begin
      {psel, penable, pwrite, enc, paddr, pwdata, pstrb} = '0;
      {mode_a, mode_b, tp, pd} = '0;
      void'($urandom(62261));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ADDR_B, 32'h0, 4'h0);
      `CHK(rd, 32'h0000_0000)
      for (int i = 0; i < 40; i++) begin
         @(posedge pclk);
         mode_a <= (i < 2) ? 8'h00 : 8'($urandom);
         mode_b <= (i < 6) ? 8'h01 : 8'($urandom);
         tp <= (i < 8) ? 4'(i) : 4'($urandom_range(7));
         pd <= (i == 3) ? 2'h3 : (i < 6) ? 2'h0 : 2'($urandom);
         // first passes force link A clocks with serializers held off, link B with serializers on
         ext_a = (i < 2) ? 8'hFE : 8'($urandom);
         ext_b = (i < 6) ? 8'hFF : 8'($urandom);
         apb(1'b1, ADDR_A, {24'h0, ext_a}, 4'hF);
         apb(1'b1, ADDR_B, {24'h0, ext_b}, 4'hF);
         apb(1'b1, ADDR_A, 32'h0000_00FF, 4'h0);
         apb(1'b0, ADDR_A, 32'h0, 4'h0);
         `CHK(rd, {24'h0, ext_a})
         apb(1'b0, ADDR_B, 32'h0, 4'h0);
         `CHK(rd, {24'h0, ext_b})
         @(negedge pclk);
         ea = expect_lanes(mode_a, ext_a, tp, ~pd[0]);
         eb = expect_lanes(mode_b, ext_b, tp, ~pd[1]);
         `CHK(lanes_a.clk_en, ea.clk_en)
         `CHK(lanes_b.clk_en, eb.clk_en)
         `CHK(lanes_a.ser_en, ea.ser_en)
         `CHK(lanes_b.ser_en, eb.ser_en)
         `CHK(lanes_a.ramp | lanes_b.ramp, ea.ramp | eb.ramp)
         `CHK({lanes_a.pattern, lanes_b.pattern}, {ea.pattern, eb.pattern})
         `CHK(rx_b, 4'($countones(eb.ser_en)))
         `CHK(rx_a, 4'($countones(ea.ser_en)))
         `CHK({pll_en, mf_en}, {2{pd != 2'h3}})
      end
      apb(1'b0, ADDR_SS, 32'h0, 4'h0);
      `CHK(rd, {16'h0000, eb.ser_en, ea.ser_en})
      apb(1'b0, ADDR_ST, 32'h0, 4'h0);
      `CHK(rd[30:0], {pd != 2'h3, 14'h0000, eb.clk_en, ea.clk_en})
      apb(1'b0, 12'h000, 32'h0, 4'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      // mid-run reset: everything dark, registers back to zero
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      `CHK({pll_en, mf_en, pready, lanes_a.clk_en, lanes_b.ser_en}, 19'h00000)
      presetn <= 1'b1;
      apb(1'b0, ADDR_A, 32'h0, 4'h0);
      `CHK(rd, 32'h0000_0000)
      @(posedge pclk);
      enc <= 1'b1;
      apb(1'b1, ADDR_A, 32'h0000_0003, 4'h1);
      @(posedge pclk);
      enc <= 1'b0;
      apb(1'b0, ADDR_A, 32'h0, 4'h0);
      `CHK(rd, 32'h0000_0003)
      apb(1'b0, ADDR_ST, 32'h0, 4'h0);
      `CHK(rd[31], 1'b1)
      apb(1'b1, ADDR_ST, 32'h8000_0000, 4'h8);
      apb(1'b0, ADDR_ST, 32'h0, 4'h0);
      `CHK(rd[31], 1'b0)
      wrap_up();
   end
endmodule : serial_link_extra_lane_enable_tb_top
`default_nettype wire
